// >>> hdl/pcc_cfg_bank.sv
// pci configuration identity, control word and status word bank
`timescale 1ns/1ps
`default_nettype none
module pcc_cfg_bank
  import pcc_pkg::*;
#(
  parameter logic [15:0] DFLT_MAKER = PCC_DFLT_MAKER,
  parameter logic [15:0] DFLT_PART  = PCC_DFLT_PART
) (
  // core clock domain
  input  wire logic         core_clk,
  input  wire logic         rst,
  // eeprom loader results, core domain
  input  wire logic         ee_done,
  input  wire logic         ee_present,
  input  wire pcc_ident_t   ee_ident,
  // core master requests and permissions
  input  wire logic         mst_req,
  output logic              mst_go,
  output logic              fbtb_diff_en,
  output logic              ident_loaded,
  // pci link clock domain
  input  wire logic         pci_clk,
  // configuration access, pci domain
  input  wire pcc_cfg_req_t cfg_req,
  output logic              cfg_ack,
  output logic      [31:0]  cfg_rdata,
  // bus events and decode hits, pci domain
  input  wire pcc_events_t  bus_evt,
  input  wire logic         mem_hit,
  input  wire logic         io_hit,
  output logic              claim,
  // open-drain error lines, low active on the bus
  output logic              system_error_line_o,
  output logic              system_error_line_oe,
  output logic              parity_error_line_o,
  output logic              parity_error_line_oe
);

  // ---------------- core domain: identity loader ----------------

  pcc_load_state_t ld_state_ff, nxt_ld_state;
  pcc_ident_t      ld_word_ff, nxt_ld_word;
  logic            ld_send;
  logic            ld_busy;
  logic            mst_go_ff, nxt_mst_go;
  logic            fbtb_diff_ff, nxt_fbtb_diff;
  logic            loaded_ff, nxt_loaded;
  logic [1:0]      core_ctl_s;

  // fall back to built-in identity when the eeprom is missing
  function automatic pcc_ident_t pick_ident(input logic present, input pcc_ident_t w);
    pcc_ident_t r;
    r = w;
    if (!present) begin
      r.maker_code_field = DFLT_MAKER;
      r.part_code_field  = DFLT_PART;
      r.fbtb_opt         = 1'b0;
      r.pm_opt           = 1'b0;
    end
    return r;
  endfunction

  // a reload request during a transfer is dropped; only idle and done accept ee_done
  always_comb begin
    nxt_ld_state = ld_state_ff;
    nxt_ld_word  = ld_word_ff;
    nxt_loaded   = loaded_ff;
    ld_send      = 1'b0;
    case (ld_state_ff)
      PCC_LD_IDLE: begin
        if (ee_done) begin
          nxt_ld_word  = pick_ident(ee_present, ee_ident);
          nxt_ld_state = PCC_LD_SEND;
        end
      end
      PCC_LD_SEND: begin
        if (!ld_busy) begin
          ld_send      = 1'b1;
          nxt_ld_state = PCC_LD_WAIT;
        end
      end
      PCC_LD_WAIT: begin
        if (!ld_busy) begin
          nxt_loaded   = 1'b1;
          nxt_ld_state = PCC_LD_DONE;
        end
      end
      PCC_LD_DONE: begin
        if (ee_done) begin
          nxt_ld_word  = pick_ident(ee_present, ee_ident);
          nxt_ld_state = PCC_LD_SEND;
        end
      end
      default: begin
        nxt_ld_state = PCC_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_state_ff <= PCC_LD_IDLE;
      ld_word_ff  <= '0;
      loaded_ff   <= 1'b0;
    end else begin
      ld_state_ff <= nxt_ld_state;
      ld_word_ff  <= nxt_ld_word;
      loaded_ff   <= nxt_loaded;
    end
  end

  // ---------------- crossings ----------------

  logic       ident_valid;
  pcc_ident_t ident_xfer;
  logic [1:0] pci_ctl;

  pcc_xfer #(.W(PCC_IDENT_W)) u_ident_xfer (
    .src_clk   (core_clk),
    .src_rst   (rst),
    .src_send  (ld_send),
    .src_data  (ld_word_ff),
    .src_busy  (ld_busy),
    .dst_clk   (pci_clk),
    .dst_rst   (rst),
    .dst_valid (ident_valid),
    .dst_data  (ident_xfer)
  );

  // control levels reach the core two core edges late
  pcc_sync2 #(.W(2)) u_ctl_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (pci_ctl),
    .q   (core_ctl_s)
  );

  // ---------------- core domain: permissions ----------------

  // core_ctl_s = {fbtb, master allow}
  always_comb begin
    nxt_mst_go    = mst_req & core_ctl_s[0];
    nxt_fbtb_diff = core_ctl_s[1];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mst_go_ff    <= 1'b0;
      fbtb_diff_ff <= 1'b0;
    end else begin
      mst_go_ff    <= nxt_mst_go;
      fbtb_diff_ff <= nxt_fbtb_diff;
    end
  end

  assign mst_go       = mst_go_ff;
  assign fbtb_diff_en = fbtb_diff_ff;
  assign ident_loaded = loaded_ff;

  // ---------------- pci domain: identity ----------------

  pcc_ident_t ident_ff, nxt_ident;

  always_comb begin
    nxt_ident = ident_ff;
    if (ident_valid) begin
      nxt_ident = ident_xfer;
    end
  end

  // built-in identity shows until the eeprom word arrives
  always_ff @(posedge pci_clk or posedge rst) begin
    if (rst) begin
      ident_ff <= '{part_code_field: DFLT_PART, maker_code_field: DFLT_MAKER,
                    fbtb_opt: 1'b0, pm_opt: 1'b0};
    end else begin
      ident_ff <= nxt_ident;
    end
  end

  // ---------------- pci domain: control and status words ----------------

  logic [15:0] cmd_ff, nxt_cmd;
  logic [15:0] stat_ff, nxt_stat;
  logic [15:0] cmd_view;
  logic [15:0] stat_view;
  logic [15:0] cmd_wmask;
  logic [15:0] w1c;
  logic [15:0] set_evt;
  logic        wr_cs;
  logic        serr_fire;
  logic        perr_fire;
  logic        dpd_evt;

  // writable bits; 3,4,5,7 and 10..15 never store anything
  always_comb begin
    cmd_wmask = PCC_CMD_WMASK;
    if (ident_ff.fbtb_opt) begin
      cmd_wmask = cmd_wmask | PCC_CMD_FBTB_MASK;
    end
  end

  // fast back-to-back bit also hides if the option is withdrawn later
  always_comb begin
    cmd_view                   = cmd_ff & cmd_wmask;
    stat_view                  = stat_ff;
    stat_view[PCC_ST_FBBC_BIT]   = ident_ff.fbtb_opt;
    stat_view[PCC_ST_NEWCAP_BIT] = ident_ff.pm_opt;
    stat_view[10:9]            = PCC_DEVSEL_MEDIUM;
  end

  assign wr_cs = cfg_req.req & cfg_req.we & (cfg_req.idx == PCC_IDX_CMDSTAT);

  // error line firing; a disabled response keeps the line quiet, but status bit 15 still records the parity error
  assign serr_fire = bus_evt.addr_par_err & cmd_view[PCC_CMD_SERR_BIT];
  assign perr_fire = bus_evt.data_par_err_tgt & cmd_view[PCC_CMD_PAR_BIT];
  assign dpd_evt   = bus_evt.mst_active & bus_evt.perr_sensed
                   & cmd_view[PCC_CMD_PAR_BIT];

  // hardware events that set sticky status flags
  always_comb begin
    set_evt                   = '0;
    set_evt[PCC_ST_DPERR_BIT] = bus_evt.addr_par_err | bus_evt.data_par_err_tgt;
    set_evt[PCC_ST_SSERR_BIT] = serr_fire;
    set_evt[PCC_ST_RMABT_BIT] = bus_evt.mst_abort_rcvd;
    set_evt[PCC_ST_RTABT_BIT] = bus_evt.tgt_abort_rcvd;
    set_evt[PCC_ST_STABT_BIT] = bus_evt.tgt_abort_sent;
    set_evt[PCC_ST_DPD_BIT]   = dpd_evt;
  end

  // byte enables steer which half of each word a write touches
  always_comb begin
    nxt_cmd = cmd_ff;
    w1c     = '0;
    if (wr_cs) begin
      if (cfg_req.be[0]) begin
        nxt_cmd[7:0] = (cmd_ff[7:0] & ~cmd_wmask[7:0])
                     | (cfg_req.wdata[7:0] & cmd_wmask[7:0]);
      end
      if (cfg_req.be[1]) begin
        nxt_cmd[15:8] = (cmd_ff[15:8] & ~cmd_wmask[15:8])
                      | (cfg_req.wdata[15:8] & cmd_wmask[15:8]);
      end
      if (cfg_req.be[2]) begin
        w1c[7:0] = cfg_req.wdata[23:16] & PCC_ST_W1C_MASK[7:0];
      end
      if (cfg_req.be[3]) begin
        w1c[15:8] = cfg_req.wdata[31:24] & PCC_ST_W1C_MASK[15:8];
      end
    end
    // a write can only clear; an event in the same cycle still wins
    nxt_stat = (stat_ff & ~w1c) | set_evt;
  end

  // control word comes up all zero, parity reaction included
  always_ff @(posedge pci_clk or posedge rst) begin
    if (rst) begin
      cmd_ff  <= PCC_CMD_RESET;
      stat_ff <= PCC_ST_RESET;
    end else begin
      cmd_ff  <= nxt_cmd;
      stat_ff <= nxt_stat;
    end
  end

  // independent levels to the core, so a one-edge skew between them is harmless
  assign pci_ctl = {cmd_view[PCC_CMD_FBTB_BIT], cmd_view[PCC_CMD_MST_BIT]};

  // ---------------- pci domain: read path ----------------

  logic [31:0] nxt_rdata;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic        ack_ff;

  // unmapped indices read as zero
  always_comb begin
    nxt_ack   = cfg_req.req;
    nxt_rdata = rdata_ff;
    if (cfg_req.req && !cfg_req.we) begin
      case (cfg_req.idx)
        PCC_IDX_ID:      nxt_rdata = {ident_ff.part_code_field, ident_ff.maker_code_field};
        PCC_IDX_CMDSTAT: nxt_rdata = {stat_view, cmd_view};
        PCC_IDX_CLASS:   nxt_rdata = PCC_CLASS_WORD;
        default:         nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pci_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
      ack_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
    end
  end

  assign cfg_rdata = rdata_ff;
  assign cfg_ack   = ack_ff;

  // ---------------- pci domain: claim and error lines ----------------

  logic claim_ff, nxt_claim;
  logic serr_oe_ff, nxt_serr_oe;
  logic perr_oe_ff, nxt_perr_oe;

  // decode hits only claim while their space is enabled
  always_comb begin
    nxt_claim   = (mem_hit & cmd_view[PCC_CMD_MEM_BIT])
                | (io_hit & cmd_view[PCC_CMD_IO_BIT]);
    nxt_serr_oe = serr_fire;
    nxt_perr_oe = perr_fire;
  end

  // one-cycle low pulses; the pull-up returns the lines high
  always_ff @(posedge pci_clk or posedge rst) begin
    if (rst) begin
      claim_ff   <= 1'b0;
      serr_oe_ff <= 1'b0;
      perr_oe_ff <= 1'b0;
    end else begin
      claim_ff   <= nxt_claim;
      serr_oe_ff <= nxt_serr_oe;
      perr_oe_ff <= nxt_perr_oe;
    end
  end

  assign claim                = claim_ff;
  assign system_error_line_oe = serr_oe_ff;
  assign parity_error_line_oe = perr_oe_ff;
  // driven value is always low, constant from reset
  assign system_error_line_o  = 1'b0;
  assign parity_error_line_o  = 1'b0;

endmodule
`default_nettype wire

// >>> hdl/pcc_pkg.sv
// shared constants, field layouts and carrier types of the pci config/command bank
package pcc_pkg;

  // configuration dword indices (byte address = 4 * index)
  localparam logic [5:0]  PCC_IDX_ID        = 6'h00;
  localparam logic [5:0]  PCC_IDX_CMDSTAT   = 6'h01;
  localparam logic [5:0]  PCC_IDX_CLASS     = 6'h02;

  // control word bit positions
  localparam int          PCC_CMD_IO_BIT    = 0;
  localparam int          PCC_CMD_MEM_BIT   = 1;
  localparam int          PCC_CMD_MST_BIT   = 2;
  localparam int          PCC_CMD_PAR_BIT   = 6;
  localparam int          PCC_CMD_SERR_BIT  = 8;
  localparam int          PCC_CMD_FBTB_BIT  = 9;

  // control word reset value and write masks
  localparam logic [15:0] PCC_CMD_RESET     = 16'h0000;
  localparam logic [15:0] PCC_CMD_WMASK     = 16'h0147;
  localparam logic [15:0] PCC_CMD_FBTB_MASK = 16'h0200;

  // status word bit positions
  localparam int          PCC_ST_DPD_BIT    = 8;
  localparam int          PCC_ST_STABT_BIT  = 11;
  localparam int          PCC_ST_RTABT_BIT  = 12;
  localparam int          PCC_ST_RMABT_BIT  = 13;
  localparam int          PCC_ST_SSERR_BIT  = 14;
  localparam int          PCC_ST_DPERR_BIT  = 15;
  localparam int          PCC_ST_NEWCAP_BIT = 4;
  localparam int          PCC_ST_FBBC_BIT   = 7;
  localparam logic [15:0] PCC_ST_W1C_MASK   = 16'hF900;
  localparam logic [15:0] PCC_ST_RESET      = 16'h0000;
  localparam logic [1:0]  PCC_DEVSEL_MEDIUM = 2'h1;

  // fixed read-only words
  localparam logic [31:0] PCC_CLASS_WORD    = 32'h0200_0000;

  // built-in identity used when no eeprom is present (values arbitrary)
  localparam logic [15:0] PCC_DFLT_MAKER    = 16'h1A2B;
  localparam logic [15:0] PCC_DFLT_PART     = 16'h3C4D;

  // identity and option bits loaded from the eeprom
  typedef struct packed {
    logic [15:0] part_code_field;
    logic [15:0] maker_code_field;
    logic        fbtb_opt;
    logic        pm_opt;
  } pcc_ident_t;

  localparam int PCC_IDENT_W = 34;

  // configuration access request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [5:0]  idx;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcc_cfg_req_t;

  // bus events seen by the pci interface logic
  typedef struct packed {
    logic addr_par_err;
    logic data_par_err_tgt;
    logic perr_sensed;
    logic mst_active;
    logic mst_abort_rcvd;
    logic tgt_abort_rcvd;
    logic tgt_abort_sent;
  } pcc_events_t;

  // eeprom identity loader states, gray along idle-send-wait-done
  typedef enum logic [1:0] {
    PCC_LD_IDLE = 2'b00,
    PCC_LD_SEND = 2'b01,
    PCC_LD_WAIT = 2'b11,
    PCC_LD_DONE = 2'b10
  } pcc_load_state_t;

endpackage

// >>> hdl/pcc_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module pcc_sync2 #(
  parameter int W = 1
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/pcc_xfer.sv
// toggle handshake carrying one word from a source to a destination clock
`timescale 1ns/1ps
`default_nettype none
module pcc_xfer #(
  parameter int W = 8
) (
  // source side
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         src_send,
  input  wire logic [W-1:0] src_data,
  output logic              src_busy,
  // destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  output logic              dst_valid,
  output logic      [W-1:0] dst_data
);

  logic [W-1:0] hold_ff, nxt_hold;
  logic         req_tgl_ff, nxt_req_tgl;
  logic         ack_s;
  logic         req_s;
  logic         seen_ff, nxt_seen;

  // source holds the word steady until the acknowledge returns
  always_comb begin
    nxt_hold    = hold_ff;
    nxt_req_tgl = req_tgl_ff;
    if (src_send && !src_busy) begin
      nxt_hold    = src_data;
      nxt_req_tgl = ~req_tgl_ff;
    end
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      hold_ff    <= '0;
      req_tgl_ff <= 1'b0;
    end else begin
      hold_ff    <= nxt_hold;
      req_tgl_ff <= nxt_req_tgl;
    end
  end

  assign src_busy = req_tgl_ff ^ ack_s;

  pcc_sync2 #(.W(1)) u_req_sync (.clk(dst_clk), .rst(dst_rst), .d(req_tgl_ff), .q(req_s));
  pcc_sync2 #(.W(1)) u_ack_sync (.clk(src_clk), .rst(src_rst), .d(seen_ff), .q(ack_s));

  // destination takes the word once per toggle; data is stable by then
  always_comb begin
    nxt_seen = req_s;
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      seen_ff   <= 1'b0;
      dst_valid <= 1'b0;
      dst_data  <= '0;
    end else begin
      seen_ff   <= nxt_seen;
      dst_valid <= req_s ^ seen_ff;
      if (req_s ^ seen_ff) begin
        dst_data <= hold_ff;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/pcc_cfg_bank_sva.sv
// concurrent checks on the ports of the pci config/command bank
`timescale 1ns/1ps
`default_nettype none
module pcc_cfg_bank_sva
  import pcc_pkg::*;
(
  // core domain
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         mst_req,
  input wire logic         mst_go,
  input wire logic         ident_loaded,
  // pci domain
  input wire logic         pci_clk,
  input wire pcc_cfg_req_t cfg_req,
  input wire logic         cfg_ack,
  input wire logic  [31:0] cfg_rdata,
  input wire pcc_events_t  bus_evt,
  input wire logic         mem_hit,
  input wire logic         io_hit,
  input wire logic         claim,
  input wire logic         system_error_line_oe,
  input wire logic         parity_error_line_oe
);
  logic [15:0] cmd_sh_ff;
  logic [15:0] nxt_cmd_sh;
  logic        rd_ctl_ff;
  logic        nxt_rd_ctl;

  // shadow of the enable bits that steer claim and the error lines
  always_comb begin
    nxt_cmd_sh = cmd_sh_ff;
    nxt_rd_ctl = cfg_req.req && !cfg_req.we && cfg_req.idx == PCC_IDX_CMDSTAT;
    if (cfg_req.req && cfg_req.we && cfg_req.idx == PCC_IDX_CMDSTAT) begin
      if (cfg_req.be[0]) nxt_cmd_sh[7:0] = cfg_req.wdata[7:0] & 8'h43;
      if (cfg_req.be[1]) nxt_cmd_sh[15:8] = cfg_req.wdata[15:8] & 8'h01;
    end
  end

  // registered beside the bank so reads line up with their ack
  always_ff @(posedge pci_clk or posedge rst) begin
    if (rst) begin
      cmd_sh_ff <= 16'h0000;
      rd_ctl_ff <= 1'b0;
    end else begin
      cmd_sh_ff <= nxt_cmd_sh;
      rd_ctl_ff <= nxt_rd_ctl;
    end
  end

  ack_follow_a: assert property (@(posedge pci_clk) disable iff (rst)
    cfg_req.req |=> cfg_ack) else $error("request without ack");
  ack_cause_a: assert property (@(posedge pci_clk) disable iff (rst)
    cfg_ack |-> $past(cfg_req.req)) else $error("ack without request");
  rdata_hold_a: assert property (@(posedge pci_clk) disable iff (rst)
    !$past(cfg_req.req && !cfg_req.we) |-> $stable(cfg_rdata)) else $error("read data moved");
  ctl_zero_a: assert property (@(posedge pci_clk) disable iff (rst)
    cfg_ack && rd_ctl_ff |-> (cfg_rdata[15:0] & 16'hFCB8) == 16'h0000)
    else $error("fixed control bit read nonzero");
  ctl_match_a: assert property (@(posedge pci_clk) disable iff (rst)
    cfg_ack && rd_ctl_ff |-> (cfg_rdata[15:0] & 16'h0143) == $past(cmd_sh_ff))
    else $error("control bits read back wrong");
  stat_fixed_a: assert property (@(posedge pci_clk) disable iff (rst)
    cfg_ack && rd_ctl_ff |-> cfg_rdata[26:25] == PCC_DEVSEL_MEDIUM) else $error("select timing");
  claim_decode_a: assert property (@(posedge pci_clk) disable iff (rst)
    claim == $past((mem_hit & cmd_sh_ff[1]) | (io_hit & cmd_sh_ff[0])))
    else $error("claim does not follow decode enables");
  serr_pulse_a: assert property (@(posedge pci_clk) disable iff (rst)
    system_error_line_oe == $past(bus_evt.addr_par_err & cmd_sh_ff[8]))
    else $error("system error line wrong");
  perr_pulse_a: assert property (@(posedge pci_clk) disable iff (rst)
    parity_error_line_oe == $past(bus_evt.data_par_err_tgt & cmd_sh_ff[6]))
    else $error("parity error line wrong");
  mst_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    mst_go |-> $past(mst_req)) else $error("master go without request");
  ident_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
    ident_loaded |=> ident_loaded) else $error("identity flag dropped");

  // main scenarios reached
  ctl_read_c: cover property (@(posedge pci_clk) disable iff (rst) cfg_ack && rd_ctl_ff);
  serr_c: cover property (@(posedge pci_clk) disable iff (rst) system_error_line_oe);
  load_c: cover property (@(posedge core_clk) disable iff (rst) $rose(ident_loaded));
endmodule

bind pcc_cfg_bank pcc_cfg_bank_sva u_sva (
  .core_clk(core_clk), .rst(rst), .mst_req(mst_req), .mst_go(mst_go),
  .ident_loaded(ident_loaded), .pci_clk(pci_clk), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .bus_evt(bus_evt), .mem_hit(mem_hit), .io_hit(io_hit),
  .claim(claim), .system_error_line_oe(system_error_line_oe),
  .parity_error_line_oe(parity_error_line_oe)
);
`default_nettype wire

// >>> verification/pcc_host_model.sv
// host bridge model issuing configuration accesses
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model
  import pcc_pkg::*;
(
  // link clock and reset
  input  wire logic       pci_clk,
  input  wire logic       rst,
  // configuration request strobe
  output var pcc_cfg_req_t cfg_req
);
  initial cfg_req = '0;

  // one-cycle strobe; released fields flip so stale values never look valid
  task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] be,
                        input logic [31:0] wd);
    while (rst !== 1'b0) @(posedge pci_clk);
    @(posedge pci_clk);
    cfg_req <= {1'b1, we, idx, be, wd};
    @(posedge pci_clk);
    cfg_req <= {1'b0, ~we, ~idx, ~be, ~wd};
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the pci config/command bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import pcc_pkg::*;
;
  // status with eeprom absent, and with both option bits loaded
  localparam logic [15:0] ST0 = {5'h00, PCC_DEVSEL_MEDIUM, 9'h000};
  localparam logic [15:0] ST1 = ST0 | 16'h0090;
  logic         core_clk, pci_clk, rst, ee_done, ee_present, mst_req, mem_hit, io_hit;
  logic         cfg_ack, claim, mst_go, fbtb_diff_en, ident_loaded, so, soe, po, poe;
  pcc_ident_t   ee_ident;
  pcc_events_t  bus_evt;
  pcc_cfg_req_t cfg_req;
  logic [31:0]  cfg_rdata, d;
  logic [15:0]  mk, pt;
  logic [63:0]  notes[$];
  logic [63:0]  nt;
  integer       seed;
  int           mismatches, checks, n;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // link clock offset so its edges never meet the core edges
  initial begin
    pci_clk = 1'b0;
    #3;
    forever #62.5 pci_clk = ~pci_clk;
  end

  pcc_cfg_bank dut (.core_clk(core_clk), .rst(rst), .ee_done(ee_done),
    .ee_present(ee_present), .ee_ident(ee_ident), .mst_req(mst_req), .mst_go(mst_go),
    .fbtb_diff_en(fbtb_diff_en), .ident_loaded(ident_loaded), .pci_clk(pci_clk),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .bus_evt(bus_evt),
    .mem_hit(mem_hit), .io_hit(io_hit), .claim(claim), .system_error_line_o(so),
    .system_error_line_oe(soe), .parity_error_line_o(po), .parity_error_line_oe(poe));
  pcc_host_model host (.pci_clk(pci_clk), .rst(rst), .cfg_req(cfg_req));

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    notes.push_back({32'hFFFF_FFFF, exp});
    host.access(1'b0, idx, 4'hF, 32'h0000_0000);
  endtask
  // writes leave an empty note so the ack still pairs up
  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    notes.push_back(64'h0);
    host.access(1'b1, idx, be, wd);
  endtask
  task automatic evt(input pcc_events_t e);
    @(posedge pci_clk);
    bus_evt <= e;
    @(posedge pci_clk);
    bus_evt <= '0;
  endtask
  task automatic ee_load(input logic pres, input pcc_ident_t id);
    @(posedge core_clk);
    ee_done <= 1'b1;
    ee_present <= pres;
    ee_ident <= id;
    @(posedge core_clk);
    ee_done <= 1'b0;
    repeat (8) @(posedge pci_clk);
  endtask
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // oldest note is compared against every ack
  always @(posedge pci_clk) begin
    if (cfg_ack === 1'b1) begin
      checks++;
      nt = (notes.size() > 0) ? notes.pop_front() : {32'hFFFF_FFFF, ~cfg_rdata};
      if ((cfg_rdata & nt[63:32]) !== (nt[31:0] & nt[63:32])) begin
        mismatches++;
        $display("BAD %0t read %h expected %h", $time, cfg_rdata, nt[31:0]);
      end
    end
  end
  // random decode hits keep the claim path busy all run
  always @(posedge pci_clk) begin
    {mem_hit, io_hit} <= rst ? 2'b00 : 2'($random(seed));
  end

  initial begin
    #200000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst = 1'b1;
    ee_done = 1'b0;
    ee_present = 1'b0;
    ee_ident = '0;
    mst_req = 1'b0;
    bus_evt = '0;
    mem_hit = 1'b0;
    io_hit = 1'b0;
    seed = 32'h5BF744C5;
    repeat (16) @(posedge core_clk);
    repeat (2) @(posedge pci_clk);
    rst <= 1'b0;
    rd(PCC_IDX_ID, {PCC_DFLT_PART, PCC_DFLT_MAKER});
    rd(PCC_IDX_CMDSTAT, {ST0, PCC_CMD_RESET});
    rd(PCC_IDX_CLASS, PCC_CLASS_WORD);
    rd(6'h3F, 32'h0000_0000);
    wr(PCC_IDX_ID, 4'hF, 32'hFFFF_FFFF);
    rd(PCC_IDX_ID, {PCC_DFLT_PART, PCC_DFLT_MAKER});
    for (n = 0; n < 6; n++) begin
      d = $random(seed);
      wr(PCC_IDX_CMDSTAT, 4'h3, d);
      rd(PCC_IDX_CMDSTAT, {ST0, d[15:0] & PCC_CMD_WMASK});
    end
    wr(PCC_IDX_CMDSTAT, 4'h0, 32'h0000_FFFF);
    rd(PCC_IDX_CMDSTAT, {ST0, d[15:0] & PCC_CMD_WMASK});
    mk = 16'($random(seed));
    pt = 16'($random(seed));
    ee_load(1'b1, {pt, mk, 2'b11});
    chk(ident_loaded, 1'b1);
    rd(PCC_IDX_ID, {pt, mk});
    wr(PCC_IDX_CMDSTAT, 4'h3, 32'h0000_FFFF);
    rd(PCC_IDX_CMDSTAT, {ST1, PCC_CMD_WMASK | PCC_CMD_FBTB_MASK});
    @(posedge core_clk);
    mst_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(mst_go, 1'b1);
    chk(fbtb_diff_en, 1'b1);
    wr(PCC_IDX_CMDSTAT, 4'h3, 32'h0000_0143);
    repeat (6) @(posedge core_clk);
    chk(mst_go, 1'b0);
    chk(fbtb_diff_en, 1'b0);
    evt(7'h7F);
    @(negedge pci_clk);
    chk(soe, 1'b1);
    chk(poe, 1'b1);
    chk(so, 1'b0);
    chk(po, 1'b0);
    rd(PCC_IDX_CMDSTAT, {ST1 | PCC_ST_W1C_MASK, 16'h0143});
    wr(PCC_IDX_CMDSTAT, 4'hC, 32'h0000_0000);
    rd(PCC_IDX_CMDSTAT, {ST1 | PCC_ST_W1C_MASK, 16'h0143});
    wr(PCC_IDX_CMDSTAT, 4'hC, 32'hA000_0000);
    rd(PCC_IDX_CMDSTAT, {ST1 | 16'h5900, 16'h0143});
    wr(PCC_IDX_CMDSTAT, 4'hC, 32'hFFFF_0000);
    rd(PCC_IDX_CMDSTAT, {ST1, 16'h0143});
    wr(PCC_IDX_CMDSTAT, 4'h3, 32'h0000_0000);
    evt(7'h78); // parity faults with every enable clear
    @(negedge pci_clk);
    chk(soe, 1'b0);
    chk(poe, 1'b0);
    rd(PCC_IDX_CMDSTAT, {ST1 | 16'h8000, 16'h0000});
    ee_load(1'b0, {pt, mk, 2'b11});
    rd(PCC_IDX_ID, {PCC_DFLT_PART, PCC_DFLT_MAKER});
    rd(PCC_IDX_CMDSTAT, {ST0 | 16'h8000, 16'h0000});
    repeat (4) @(posedge pci_clk);
    if (notes.size() != 0) begin
      mismatches++;
      $display("BAD %0t unanswered requests %0d", $time, notes.size());
    end
    finish_test();
  end
endmodule
`default_nettype wire
